// ### logic/pdb_pkg.sv
`default_nettype none
package pdb_pkg;
	// Host address layout (20-bit latched address)
	localparam int ADDR_W       = 20;
	localparam int WIN_SEL_BIT  = 17;
	localparam int REGION_LO    = 18;
	localparam int REGION_HI    = 19;
	localparam int LOW_ADDR_W   = 16;
	localparam int PAGE_W       = 10;
	localparam int PAGE_BASE_W  = 5;
	localparam int BANK_ADDR_W  = 18;
	localparam int ROW_W        = 9;
	localparam int NUM_BANKS    = 4;
	localparam int PAGE_SUM_W   = 6;
	// Region decode of the two highest address bits
	localparam logic [1:0] REGION_MAIN  = 2'h0;
	localparam logic [1:0] REGION_PAGED = 2'h1;
	// Page register select decode on latched address bits 6 and 5
	localparam int PG_SEL_LO    = 5;
	localparam int PG_SEL_HI    = 6;
	localparam logic [1:0] PG_SEL_CODE = 2'h0;
	// Installed paged memory in 64K units: two or three banks of 512K
	localparam logic [5:0] PAGED_UNITS_BASE = 6'h10;
	localparam logic [5:0] PAGED_UNITS_EXP  = 6'h18;
	// Watchdog timing
	localparam int CLK_HZ       = 40_000_000;
	localparam int WDOG_NS      = 10_000;
	localparam int WDOG_CYCLES  = (WDOG_NS * (CLK_HZ / 1_000_000)) / 1_000;
	localparam int WDOG_W       = 9;
	localparam logic [0:0] PAGE_RESET = 1'h0;
	typedef enum logic [2:0] {
		PDB_IDLE,
		PDB_ROW,
		PDB_MUX,
		PDB_CAS,
		PDB_DONE,
		PDB_END
	} pdb_state_e;
endpackage : pdb_pkg
`default_nettype wire

// ### logic/pdb_paged_dram_ctrl.sv
// Operation
// [RULE1] Three or four banks, each 512K on a 16-bit data path.
// [RULE2] Bank one takes row and column only from the latched host address.
// [RULE3] Banks two to four share a mux substituting page outputs for address lines.
// [RULE4] Ten-bit readable page register holds low and high window bases.
// [RULE5] Window select address bit picks which page base drives the address.
// [RULE6] Page base added to lower address bits on 64K granularity.
// [RULE7] Upper sum bits decode one-hot bank select; only selected bank gets CAS.
// [RULE8] Paged addresses past installed memory wrap; expansion input sizes memory.
// [RULE9] Two top address bits classify main, paged or other; other gets no CAS.
// [RULE10] Page register strobes decoded from select, read, write and two address bits.
// [RULE11] State machine sequences RAS, CAS, mux select and synchronous ready.
// [RULE12] High lane CAS gated by high byte enable, low lane by low address bit.
// [RULE13] Refresh cycles with both lanes off get RAS-only refresh on all banks.
// [RULE14] Refresh may be held off by at most one bus cycle.
// [RULE15] Watchdog counter restarts at each bus cycle on latch enable.
// [RULE16] Watchdog timeout about ten microseconds.
// [RULE17] Timeout gives one-clock low pulse latched to drive asynchronous ready.
// [RULE18] Watchdog ready latch cleared by delayed latch enable of next cycle; the code clears it on the shifted latch enable.
// [RULE19] Watchdog period stays well below the refresh period.
// [RULE20] Ready inputs are pulsed active briefly, otherwise inactive.
// [RULE21] Delayed latch enable rises late, falls promptly with latch enable.
// [RULE22] Shifted latch enable copies latch enable on falling-edge timing.
// [RULE23] Reset puts the RAM control state machine in idle.
// [RULE24] Watchdog-ended cycle asserts no bank select or CAS.
`default_nettype none
module pdb_paged_dram_ctrl #(
	parameter int WDOG_CYCLES = pdb_pkg::WDOG_CYCLES
) (
	input  wire logic                         clk,
	input  wire logic                         arst_n,
	input  wire logic                         ale,
	input  wire logic [pdb_pkg::ADDR_W-1:0]   host_addr,
	input  wire logic                         high_byte_enable_n,
	input  wire logic                         periph_select_four_n,
	input  wire logic                         buffered_read_n,
	input  wire logic                         buffered_write_n,
	input  wire logic                         ram_expansion_present_n,
	input  wire logic [pdb_pkg::PAGE_W-1:0]   page_wdata,
	output logic      [pdb_pkg::PAGE_W-1:0]   page_rdata,
	output logic                              page_rdata_oe,
	output logic                              page_reg_read_n,
	output logic                              page_reg_write_n,
	output logic      [pdb_pkg::ROW_W-1:0]    main_addr,
	output logic      [pdb_pkg::ROW_W-1:0]    paged_addr,
	output logic                              row_col_select,
	output logic                              ras_n,
	output logic      [pdb_pkg::NUM_BANKS-1:0] bank_sel,
	output logic      [pdb_pkg::NUM_BANKS-1:0] cas_hi_n,
	output logic      [pdb_pkg::NUM_BANKS-1:0] cas_lo_n,
	output logic                              sync_ready,
	output logic                              async_ready,
	output logic                              timeout_pulse_n,
	output logic                              delayed_latch_enable,
	output logic                              shifted_latch_enable
);
	localparam int AW = pdb_pkg::ADDR_W;
	localparam int PW = pdb_pkg::PAGE_BASE_W;
	localparam int NB = pdb_pkg::NUM_BANKS;
	localparam int RW = pdb_pkg::ROW_W;
	localparam int WW = pdb_pkg::WDOG_W;
	localparam int LOW_BIT = pdb_pkg::LOW_ADDR_W;

	typedef struct packed {
		logic                   rst_meta;
		logic                   rst_sync;
		logic                   ale_d;
		logic                   ale_shift;
		logic [AW-1:0]          la;
		logic                   latched_high_byte_en;
		logic                   latched_low_byte_sel_n;
		logic [pdb_pkg::PAGE_W-1:0] page;
		pdb_pkg::pdb_state_e    state;
		logic [RW-1:0]          main_addr;
		logic [RW-1:0]          paged_addr;
		logic                   row_col_select;
		logic                   ras_n;
		logic [NB-1:0]          bank_sel;
		logic [NB-1:0]          cas_hi_n;
		logic [NB-1:0]          cas_lo_n;
		logic                   sync_ready;
		logic [WW-1:0]          wdog_cnt;
		logic                   wdog_armed;
		logic                   timeout_pulse_n;
		logic                   watchdog_ready_n;
		logic                   async_ready;
		logic                   pg_rd_n;
		logic                   pg_wr_n;
		logic                   pg_wr_d_n;
		logic [pdb_pkg::PAGE_W-1:0] page_rdata;
		logic                   page_rdata_oe;
	} pdb_state_s;

	// Value held during and just after reset: all strobes inactive, machine idle
	localparam pdb_state_s RST_ST = '{
		state:            pdb_pkg::PDB_IDLE,
		ras_n:            1'b1,
		cas_hi_n:         '1,
		cas_lo_n:         '1,
		timeout_pulse_n:  1'b1,
		watchdog_ready_n: 1'b1,
		pg_rd_n:          1'b1,
		pg_wr_n:          1'b1,
		pg_wr_d_n:        1'b1,
		default:          '0
	};

	pdb_state_s st_reg;
	pdb_state_s st_next;
	logic       ale_shift_fall;

	// Falling-edge half of the latch enable delay
	always_ff @(negedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ale_shift_fall <= 1'b0;
		end else begin
			ale_shift_fall <= ale; // [RULE22]
		end
	end

	// Row/column pick: upper half of the bank address on row, bits 9 down to 1 on column
	function automatic logic [RW-1:0] pdb_rowcol(input logic [pdb_pkg::BANK_ADDR_W-1:0] a,
			input logic col);
		pdb_rowcol = col ? a[RW:1] : a[pdb_pkg::BANK_ADDR_W-1:RW];
	endfunction : pdb_rowcol

	// Fold a page sum back into installed paged memory; the sum never exceeds twice its size
	function automatic logic [pdb_pkg::PAGE_SUM_W-1:0] pdb_wrap(
			input logic [pdb_pkg::PAGE_SUM_W-1:0] sum,
			input logic [pdb_pkg::PAGE_SUM_W-1:0] units);
		logic [pdb_pkg::PAGE_SUM_W-1:0] w;
		w = (sum >= units) ? sum - units : sum;
		pdb_wrap = (w >= units) ? w - units : w;
	endfunction : pdb_wrap

	// One-hot bank select from region and wrapped page units
	function automatic logic [NB-1:0] pdb_bank(input logic in_main, input logic in_paged,
			input logic [pdb_pkg::PAGE_SUM_W-1:0] units);
		pdb_bank = '0;
		if (in_main) begin
			pdb_bank[0] = 1'b1;
		end else if (in_paged) begin
			pdb_bank[units[4:3] + 2'h1] = 1'b1;
		end
	endfunction : pdb_bank

	// Per-bank column strobe for one byte lane, active low
	function automatic logic [NB-1:0] pdb_lane_cas(input logic [NB-1:0] banks,
			input logic lane_on);
		pdb_lane_cas = ~(banks & {NB{lane_on}});
	endfunction : pdb_lane_cas

	logic [PW-1:0]               page_base;
	logic [pdb_pkg::PAGE_SUM_W-1:0] page_sum;
	logic [pdb_pkg::PAGE_SUM_W-1:0] page_units;
	logic [pdb_pkg::PAGE_SUM_W-1:0] page_wrapped;
	logic [pdb_pkg::BANK_ADDR_W-1:0] phys_paged;
	logic [1:0]                  region;
	logic                        is_main;
	logic                        is_paged;
	logic                        refresh;
	logic [NB-1:0]               bank_dec;
	logic                        page_hit;
	logic                        dle_now;
	logic                        cycle_start;

	always_comb begin
		region = {st_reg.la[pdb_pkg::REGION_HI], st_reg.la[pdb_pkg::REGION_LO]};
		is_main  = (region == pdb_pkg::REGION_MAIN); // [RULE9]
		is_paged = (region == pdb_pkg::REGION_PAGED); // [RULE9]
		// Window select bit picks low or high page base
		page_base = st_reg.la[pdb_pkg::WIN_SEL_BIT] ? st_reg.page[pdb_pkg::PAGE_W-1:PW]
			: st_reg.page[PW-1:0]; // [RULE4] [RULE5]
		page_sum = {1'b0, page_base} + {5'h00, st_reg.la[LOW_BIT]}; // [RULE6]
		page_units = ram_expansion_present_n ? pdb_pkg::PAGED_UNITS_BASE
			: pdb_pkg::PAGED_UNITS_EXP; // [RULE8]
		page_wrapped = pdb_wrap(page_sum, page_units); // [RULE8]
		phys_paged = {page_wrapped[2:0], st_reg.la[pdb_pkg::LOW_ADDR_W-1:1]}; // [RULE3] [RULE6]
		bank_dec = pdb_bank(is_main, is_paged, page_wrapped); // [RULE1] [RULE7]
		refresh = !st_reg.latched_high_byte_en && st_reg.latched_low_byte_sel_n; // [RULE13]
		page_hit = !periph_select_four_n
			&& ({st_reg.la[pdb_pkg::PG_SEL_HI], st_reg.la[pdb_pkg::PG_SEL_LO]}
			== pdb_pkg::PG_SEL_CODE); // [RULE10]
		// Address is only valid while latch enable is high, so latch on the live copy
		dle_now = ale && ale_shift_fall; // [RULE21]
		cycle_start = st_reg.ale_shift && !ale_shift_fall && st_reg.watchdog_ready_n
			&& (is_main || is_paged || refresh); // [RULE11]
	end

	always_comb begin
		st_next = st_reg;
		st_next.rst_meta = 1'b1;
		st_next.rst_sync = st_reg.rst_meta;
		// Delayed latch enable: rise waits for falling edge, fall passes at once
		st_next.ale_shift = ale_shift_fall; // [RULE22]
		st_next.ale_d = dle_now; // [RULE21]
		if (dle_now) begin
			st_next.la = host_addr;
			st_next.latched_high_byte_en = !high_byte_enable_n; // [RULE12]
			st_next.latched_low_byte_sel_n = host_addr[0]; // [RULE12]
		end
		// Page register strobes and access
		st_next.pg_rd_n = !(page_hit && !buffered_read_n); // [RULE10]
		st_next.pg_wr_n = !(page_hit && !buffered_write_n); // [RULE10]
		st_next.pg_wr_d_n = st_reg.pg_wr_n;
		if (!st_reg.pg_wr_n && st_reg.pg_wr_d_n) begin
			st_next.page = page_wdata; // [RULE4]
		end
		st_next.page_rdata_oe = !st_reg.pg_rd_n;
		st_next.page_rdata = st_reg.pg_rd_n ? '0 : st_reg.page; // [RULE4]
		// Address muxes for bank one and the paged banks
		st_next.main_addr = pdb_rowcol(st_reg.la[pdb_pkg::BANK_ADDR_W:1],
			st_reg.row_col_select); // [RULE2]
		st_next.paged_addr = pdb_rowcol(phys_paged, st_reg.row_col_select); // [RULE3]
		// Ready pulses are single-cycle by default
		st_next.sync_ready = 1'b0; // [RULE20]
		case (st_reg.state)
			pdb_pkg::PDB_IDLE: begin
				st_next.ras_n = 1'b1;
				st_next.row_col_select = 1'b0;
				st_next.cas_hi_n = '1;
				st_next.cas_lo_n = '1;
				st_next.bank_sel = '0;
				if (cycle_start) begin
					st_next.state = pdb_pkg::PDB_ROW;
					st_next.ras_n = 1'b0; // [RULE11]
				end
			end
			pdb_pkg::PDB_ROW: begin
				st_next.row_col_select = 1'b1; // [RULE11]
				st_next.state = pdb_pkg::PDB_MUX;
			end
			pdb_pkg::PDB_MUX: begin
				if (!st_reg.watchdog_ready_n) begin
					st_next.state = pdb_pkg::PDB_END; // [RULE24]
				end else if (!buffered_read_n || !buffered_write_n || refresh) begin
					if (!refresh) begin
						st_next.bank_sel = bank_dec; // [RULE7]
						st_next.cas_hi_n = pdb_lane_cas(bank_dec,
							st_reg.latched_high_byte_en); // [RULE12] [RULE7]
						st_next.cas_lo_n = pdb_lane_cas(bank_dec,
							!st_reg.latched_low_byte_sel_n); // [RULE12] [RULE7]
					end
					st_next.state = pdb_pkg::PDB_CAS; // [RULE13]
				end
			end
			pdb_pkg::PDB_CAS: begin
				st_next.sync_ready = !refresh; // [RULE11] [RULE20]
				st_next.state = pdb_pkg::PDB_DONE;
			end
			pdb_pkg::PDB_DONE: begin
				st_next.state = pdb_pkg::PDB_END;
			end
			pdb_pkg::PDB_END: begin
				st_next.ras_n = 1'b1;
				st_next.cas_hi_n = '1;
				st_next.cas_lo_n = '1;
				st_next.bank_sel = '0; // [RULE24]
				st_next.row_col_select = 1'b0;
				if (!ale) begin
					st_next.state = pdb_pkg::PDB_IDLE;
				end
			end
			default: begin
				st_next.state = pdb_pkg::PDB_IDLE;
			end
		endcase
		// Watchdog: restarts every bus cycle, pulses low once at terminal count
		st_next.timeout_pulse_n = 1'b1;
		if (ale) begin
			st_next.wdog_cnt = '0; // [RULE15]
			st_next.wdog_armed = 1'b1;
		end else if (st_reg.wdog_armed) begin
			if (st_reg.wdog_cnt == WW'(WDOG_CYCLES - 1)) begin
				st_next.timeout_pulse_n = 1'b0; // [RULE16] [RULE17] [RULE19]
				st_next.wdog_armed = 1'b0;
			end else begin
				st_next.wdog_cnt = st_reg.wdog_cnt + WW'(1); // [RULE16]
			end
		end
		// Set/reset latch: timeout sets, shifted latch enable of next cycle clears
		if (!st_reg.timeout_pulse_n) begin
			st_next.watchdog_ready_n = 1'b0; // [RULE17]
		end else if (st_reg.ale_shift) begin
			st_next.watchdog_ready_n = 1'b1; // [RULE18]
		end
		st_next.async_ready = !st_next.watchdog_ready_n; // [RULE17]
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= RST_ST;
		end else if (!st_reg.rst_sync) begin
			st_reg <= RST_ST;
			st_reg.rst_meta <= 1'b1;
			st_reg.rst_sync <= st_reg.rst_meta;
			st_reg.state <= pdb_pkg::PDB_IDLE; // [RULE23]
			st_reg.ras_n <= 1'b1;
			st_reg.cas_hi_n <= '1;
			st_reg.cas_lo_n <= '1;
			st_reg.timeout_pulse_n <= 1'b1;
			st_reg.watchdog_ready_n <= 1'b1;
			st_reg.pg_rd_n <= 1'b1;
			st_reg.pg_wr_n <= 1'b1;
			st_reg.pg_wr_d_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign page_rdata           = st_reg.page_rdata;
	assign page_rdata_oe        = st_reg.page_rdata_oe;
	assign page_reg_read_n      = st_reg.pg_rd_n;
	assign page_reg_write_n     = st_reg.pg_wr_n;
	assign main_addr            = st_reg.main_addr;
	assign paged_addr           = st_reg.paged_addr;
	assign row_col_select       = st_reg.row_col_select;
	assign ras_n                = st_reg.ras_n;
	assign bank_sel             = st_reg.bank_sel;
	assign cas_hi_n             = st_reg.cas_hi_n;
	assign cas_lo_n             = st_reg.cas_lo_n;
	assign sync_ready           = st_reg.sync_ready;
	assign async_ready          = st_reg.async_ready;
	assign timeout_pulse_n      = st_reg.timeout_pulse_n;
	assign delayed_latch_enable = st_reg.ale_d;
	assign shifted_latch_enable = st_reg.ale_shift;
endmodule : pdb_paged_dram_ctrl
`default_nettype wire

// ### tb/pdb_assertions.sv
`default_nettype none
module pdb_checker #(
	parameter int WDOG_CYCLES = 20
) (
	input wire logic	clk,
	input wire logic	arst_n,
	input wire logic	ale,
	input wire logic	periph_select_four_n,
	input wire logic	buffered_write_n,
	input wire logic	page_reg_read_n,
	input wire logic	page_reg_write_n,
	input wire logic	ras_n,
	input wire logic [3:0]	bank_sel,
	input wire logic [3:0]	cas_hi_n,
	input wire logic [3:0]	cas_lo_n,
	input wire logic	sync_ready,
	input wire logic	async_ready,
	input wire logic	timeout_pulse_n,
	input wire logic	delayed_latch_enable
);
	logic [15:0] low_cnt;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			low_cnt <= 16'h0000;
		else if (ale)
			low_cnt <= 16'h0000;
		else
			low_cnt <= low_cnt + 16'h0001;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_cas_on;
		!(&(cas_hi_n & cas_lo_n));
	endsequence
	sequence s_timeout;
		$fell(timeout_pulse_n);
	endsequence
	bank_onehot_a: assert property ($onehot0(bank_sel))
		else $error("bank select not one-hot");
	cas_in_bank_a: assert property (((~cas_hi_n | ~cas_lo_n) & ~bank_sel) == 4'h0)
		else $error("column strobe on unselected bank");
	cas_needs_ras_a: assert property (s_cas_on |-> !ras_n)
		else $error("column strobe without row strobe");
	sync_pulse_a: assert property (sync_ready |=> !sync_ready)
		else $error("sync ready longer than one cycle");
	sync_after_cas_a: assert property (sync_ready |-> $past(!(&(cas_hi_n & cas_lo_n))))
		else $error("sync ready without prior column strobe");
	timeout_latch_a: assert property (!timeout_pulse_n |=> timeout_pulse_n && async_ready)
		else $error("timeout pulse not one cycle or not latched");
	timeout_span_a: assert property (s_timeout |-> low_cnt >= WDOG_CYCLES - 3 && low_cnt <= WDOG_CYCLES + 1)
		else $error("watchdog timeout at wrong count");
	ready_clear_a: assert property ($rose(delayed_latch_enable) |-> ##[1:3] !async_ready)
		else $error("watchdog ready not cleared by next cycle");
	strobe_decode_a: assert property (!page_reg_write_n |-> $past(!periph_select_four_n && !buffered_write_n) && page_reg_read_n)
		else $error("page write strobe without select and write");
	dle_fall_a: assert property (!ale && $past(!ale) |-> !delayed_latch_enable)
		else $error("delayed latch enable did not fall");
	timeout_no_cas_a: assert property (async_ready |-> &(cas_hi_n & cas_lo_n))
		else $error("column strobe in watchdog cycle");
endmodule : pdb_checker
bind pdb_paged_dram_ctrl pdb_checker #(.WDOG_CYCLES(WDOG_CYCLES)) u_pdb_checker (
	.clk(clk), .arst_n(arst_n), .ale(ale), .periph_select_four_n(periph_select_four_n),
	.buffered_write_n(buffered_write_n), .page_reg_read_n(page_reg_read_n),
	.page_reg_write_n(page_reg_write_n), .ras_n(ras_n), .bank_sel(bank_sel),
	.cas_hi_n(cas_hi_n), .cas_lo_n(cas_lo_n), .sync_ready(sync_ready),
	.async_ready(async_ready), .timeout_pulse_n(timeout_pulse_n),
	.delayed_latch_enable(delayed_latch_enable));
`default_nettype wire

// ### tb/pdb_host_model.sv
`default_nettype none
module pdb_host_model (
	input wire logic	clk,
	output var logic	ale,
	output var logic [19:0]	host_addr,
	output var logic	high_byte_enable_n,
	output var logic	periph_select_four_n,
	output var logic	buffered_read_n,
	output var logic	buffered_write_n,
	output var logic [9:0]	page_wdata,
	input wire logic [3:0]	bank_sel,
	input wire logic [3:0]	cas_hi_n,
	input wire logic [3:0]	cas_lo_n,
	input wire logic	ras_n,
	input wire logic	sync_ready,
	input wire logic	async_ready,
	input wire logic [9:0]	page_rdata,
	input wire logic	page_rdata_oe,
	input wire logic	page_reg_write_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] obs_bank, obs_hi, obs_lo;
	logic obs_ras, obs_sync, obs_async, obs_pw;
	logic [9:0] obs_rd;
	initial begin
		{ale, host_addr, page_wdata} = '0;
		{high_byte_enable_n, periph_select_four_n, buffered_read_n, buffered_write_n} = 4'hF;
	end
	// One bus cycle, held until either ready is seen; refresh is a read with both lanes off
	task automatic bus(input logic [19:0] a, input logic bhe_n, input logic wr,
			input logic pcs, input logic [9:0] wd);
		int i;
		{obs_bank, obs_hi, obs_lo, obs_ras, obs_sync, obs_async, obs_pw, obs_rd} = '0;
		@(posedge clk);
		ale <= 1'b1;
		host_addr <= a;
		high_byte_enable_n <= bhe_n;
		periph_select_four_n <= ~pcs;
		page_wdata <= wd;
		repeat (2) @(posedge clk);
		ale <= 1'b0;
		host_addr <= ~a; // Multiplexed bus turns to data, address gone
		@(posedge clk);
		buffered_write_n <= ~wr;
		buffered_read_n <= wr;
		for (i = 0; i < 60 && !(obs_sync || obs_async); i++) begin
			@(negedge clk);
			obs_bank |= bank_sel;
			obs_hi |= ~cas_hi_n;
			obs_lo |= ~cas_lo_n;
			obs_ras |= ~ras_n;
			obs_sync |= sync_ready;
			obs_async |= async_ready;
			obs_pw |= ~page_reg_write_n;
			if (page_rdata_oe)
				obs_rd = page_rdata;
		end
		@(posedge clk);
		{buffered_write_n, buffered_read_n, periph_select_four_n} <= 3'h7;
		page_wdata <= ~wd;
		@(posedge clk);
	endtask : bus
endmodule : pdb_host_model
`default_nettype wire

// ### tb/test_paged_dram_bank_controller.sv
`default_nettype none
module test_paged_dram_bank_controller;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, arst_n, ale, high_byte_enable_n, periph_select_four_n, buffered_read_n;
	logic buffered_write_n, ram_expansion_present_n, page_rdata_oe, ras_n, sync_ready;
	logic async_ready, page_reg_write_n;
	logic [19:0] host_addr;
	logic [9:0] page_wdata, page_rdata;
	logic [3:0] bank_sel, cas_hi_n, cas_lo_n;
	int err_total = 0;
	int n_checks = 0;
	pdb_paged_dram_ctrl #(.WDOG_CYCLES(20)) u_pdb_paged_dram_ctrl (
		.clk(clk), .arst_n(arst_n), .ale(ale), .host_addr(host_addr),
		.high_byte_enable_n(high_byte_enable_n), .periph_select_four_n(periph_select_four_n),
		.buffered_read_n(buffered_read_n), .buffered_write_n(buffered_write_n),
		.ram_expansion_present_n(ram_expansion_present_n), .page_wdata(page_wdata),
		.page_rdata(page_rdata), .page_rdata_oe(page_rdata_oe), .page_reg_read_n(),
		.page_reg_write_n(page_reg_write_n), .main_addr(), .paged_addr(),
		.row_col_select(), .ras_n(ras_n), .bank_sel(bank_sel), .cas_hi_n(cas_hi_n),
		.cas_lo_n(cas_lo_n), .sync_ready(sync_ready), .async_ready(async_ready),
		.timeout_pulse_n(), .delayed_latch_enable(), .shifted_latch_enable());
	pdb_host_model u_pdb_host_model (
		.clk(clk), .ale(ale), .host_addr(host_addr), .high_byte_enable_n(high_byte_enable_n),
		.periph_select_four_n(periph_select_four_n), .buffered_read_n(buffered_read_n),
		.buffered_write_n(buffered_write_n), .page_wdata(page_wdata), .bank_sel(bank_sel),
		.cas_hi_n(cas_hi_n), .cas_lo_n(cas_lo_n), .ras_n(ras_n), .sync_ready(sync_ready),
		.async_ready(async_ready), .page_rdata(page_rdata), .page_rdata_oe(page_rdata_oe),
		.page_reg_write_n(page_reg_write_n));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic check(input string nm, input logic [19:0] e, input logic [19:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	// Paged bank from page base plus address bit 16, wrapping over installed banks
	function automatic logic [3:0] pbank(input logic [9:0] pg, input logic [19:0] a,
			input logic ex_n);
		int s;
		s = (a[17] ? pg[9:5] : pg[4:0]) + a[16];
		s = s % (ex_n ? 16 : 24);
		return 4'h2 << (s / 8);
	endfunction : pbank
	logic [9:0] pg_t[5] = '{10'h003, 10'h120, 10'h010, 10'h010, 10'h017};
	logic [19:0] ad_t[5] = '{20'h40000, 20'h70000, 20'h50000, 20'h50000, 20'h50000};
	logic ex_t[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	initial begin
		logic [19:0] a;
		arst_n = 1'b0;
		ram_expansion_present_n = 1'b1;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		check("ras idle", 20'h1, ras_n);
		check("bank idle", 20'h0, bank_sel);
		u_pdb_host_model.bus(20'hC0000, 1'b1, 1'b1, 1'b1, 10'h2A5);
		check("page strobe", 20'h1, u_pdb_host_model.obs_pw);
		u_pdb_host_model.bus(20'hC0000, 1'b1, 1'b0, 1'b1, 10'h000);
		check("page read", 20'h2A5, u_pdb_host_model.obs_rd);
		for (int i = 0; i < 3; i++) begin
			a = 20'h01234 | (i == 2);
			u_pdb_host_model.bus(a, i == 1, i == 1, 1'b0, 10'h000);
			check("main bank", 20'h1, u_pdb_host_model.obs_bank);
			check("hi lane", (i == 1) ? 20'h0 : 20'h1, u_pdb_host_model.obs_hi);
			check("lo lane", (i == 2) ? 20'h0 : 20'h1, u_pdb_host_model.obs_lo);
			check("sync", 20'h1, u_pdb_host_model.obs_sync);
		end
		for (int i = 0; i < 5; i++) begin
			u_pdb_host_model.bus(20'hC0000, 1'b1, 1'b1, 1'b1, pg_t[i]);
			ram_expansion_present_n <= ex_t[i];
			u_pdb_host_model.bus(ad_t[i], 1'b0, 1'b0, 1'b0, 10'h000);
			a = pbank(pg_t[i], ad_t[i], ex_t[i]);
			check("paged bank", a, u_pdb_host_model.obs_bank);
			check("paged cas", a, u_pdb_host_model.obs_lo);
		end
		u_pdb_host_model.bus(20'hC1000, 1'b0, 1'b0, 1'b0, 10'h000);
		check("other bank", 20'h0, u_pdb_host_model.obs_bank);
		check("other cas", 20'h0, u_pdb_host_model.obs_hi | u_pdb_host_model.obs_lo);
		check("watchdog", 20'h1, u_pdb_host_model.obs_async);
		u_pdb_host_model.bus(20'h00001, 1'b1, 1'b0, 1'b0, 10'h000);
		check("refresh cas", 20'h0, u_pdb_host_model.obs_hi | u_pdb_host_model.obs_lo);
		check("refresh ras", 20'h1, u_pdb_host_model.obs_ras);
		check("refresh sync", 20'h0, u_pdb_host_model.obs_sync);
		summarize();
	end
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		summarize();
	end
endmodule : test_paged_dram_bank_controller
`default_nettype wire
